// >>> core/adc_regs_pkg.sv
// Shared constants and carriers for the converter status and result block.
// Assumes an 8051-style SFR bus with byte and single-bit access.
package adc_regs_pkg;

    // ------------------------------------------------------------------
    // SFR addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'hd8;
    localparam logic [7:0] ADDR_MODE = 8'hd1;
    localparam logic [7:0] ADDR_DECIM = 8'hd4;
    localparam logic [7:0] ADDR_P_RES_L = 8'hd9;
    localparam logic [7:0] ADDR_P_RES_M = 8'hda;
    localparam logic [7:0] ADDR_P_RES_H = 8'hdb;
    localparam logic [7:0] ADDR_A_RES_L = 8'hdc;
    localparam logic [7:0] ADDR_A_RES_H = 8'hdd;
    localparam logic [7:0] ADDR_P_OFF_L = 8'he1;
    localparam logic [7:0] ADDR_P_OFF_M = 8'he2;
    localparam logic [7:0] ADDR_P_OFF_H = 8'he3;
    localparam logic [7:0] ADDR_A_OFF_L = 8'he4;
    localparam logic [7:0] ADDR_A_OFF_H = 8'he5;
    localparam logic [7:0] ADDR_P_GAIN_L = 8'he9;
    localparam logic [7:0] ADDR_P_GAIN_M = 8'hea;
    localparam logic [7:0] ADDR_P_GAIN_H = 8'heb;
    localparam logic [7:0] ADDR_A_GAIN_L = 8'hec;
    localparam logic [7:0] ADDR_A_GAIN_H = 8'hed;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int BIT_P_RDY = 7;
    localparam int BIT_A_RDY = 6;
    localparam int BIT_CAL = 5;
    localparam int BIT_NOREF = 4;
    localparam int BIT_P_ERR = 3;
    localparam int BIT_A_ERR = 2;
    localparam int BIT_P_EN = 5;
    localparam int BIT_A_EN = 4;
    localparam logic [2:0] MODE_PDOWN = 3'h0;
    localparam logic [2:0] MODE_IDLE = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [7:0] MODE_WMASK = 8'h37;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] DECIM_RST = 8'h45;
    localparam logic [23:0] FACT_P_OFF = 24'h800000;
    localparam logic [23:0] FACT_P_GAIN = 24'h500000;
    localparam logic [15:0] FACT_A_OFF = 16'h8000;
    localparam logic [15:0] FACT_A_GAIN = 16'h5000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic val;
    } bit_req_t;

    typedef struct packed {
        logic done;
        logic is_cal;
        logic clamped;
        logic cal_fail;
        logic [23:0] result;
        logic [23:0] offset;
        logic [23:0] gain;
    } conv_event_t;

endpackage : adc_regs_pkg

// >>> core/conv_channel.sv
// One converter's ready and error flags, result and coefficients.
// Assumes completion events are one-cycle pulses on sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module conv_channel
    import adc_regs_pkg::*;
#(
    parameter int W = 24,
    parameter logic [W-1:0] OFF_INIT = '0,
    parameter logic [W-1:0] GAIN_INIT = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire conv_event_t ev_i,
    input wire logic start_i,
    input wire logic sw_clr_i,
    input wire logic force_ones_i,
    output logic ready_o,
    output logic error_o,
    output logic cal_done_o,
    output logic [W-1:0] result_o,
    output logic [W-1:0] offset_o,
    output logic [W-1:0] gain_o
);

    logic accept;

    // Events while ready is set are dropped
    assign accept = ev_i.done & ~ready_o; // R03
    assign cal_done_o = accept & ev_i.is_cal;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
        end else if (ev_i.done) begin
            ready_o <= 1'b1; // R01 R22
        end else if (start_i | sw_clr_i) begin
            ready_o <= 1'b0; // R02
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            error_o <= 1'b0;
        end else if (accept) begin
            // R08 R09
            error_o <= ev_i.clamped | (force_ones_i & ~ev_i.is_cal)
                | (ev_i.is_cal & ev_i.cal_fail);
        end else if (start_i) begin
            error_o <= 1'b0; // R10
        end
    end

    // ------------------------------------------------------------------
    // Data
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            result_o <= '0;
        end else if (accept & ~ev_i.is_cal) begin
            result_o <= force_ones_i ? '1 : ev_i.result[W-1:0]; // R07
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            offset_o <= OFF_INIT; // R17
            gain_o <= GAIN_INIT;
        end else if (cal_done_o & ~ev_i.cal_fail) begin
            offset_o <= ev_i.offset[W-1:0]; // R15 R16
            gain_o <= ev_i.gain[W-1:0];
        end
    end

endmodule : conv_channel
`default_nettype wire

// >>> core/adc_status_regs.sv
// Status, mode, filter, result and coefficient SFRs of a dual converter.
// Assumes an 8051 core drives the SFR byte and bit ports on sys_clk_i.
//
// Functional notes
// R01: Primary completion sets primary ready bit 7.
// R02: Ready cleared by zero write or start.
// R03: Set primary ready blocks further result writes.
// R04: Bit 6 is auxiliary ready, same behaviour.
// R05: Calibration end sets bit 5; start clears.
// R06: Missing reference tracked only while converter active.
// R07: Missing external reference forces results all ones.
// R08: Clamped primary result sets error bit 3.
// R09: Failed calibration update also sets primary error.
// R10: Start write clears the primary error flag.
// R11: Bit 2 is auxiliary error, same behaviour.
// R12: Status at D8, resets 00, bit addressable.
// R13: Primary result is three result bytes.
// R14: Auxiliary result is two result bytes.
// R15: Primary offset and gain, three bytes each.
// R16: Auxiliary offset and gain, two bytes each.
// R17: Coefficients load factory values at reset.
// R18: Filter register sets decimation for both.
// R19: Unmapped reads undefined; software avoids them.
// R20: Mode field codes; single conversion returns 000.
// R21: Enable bit runs converter; clear powers down.
// R22: Completion beats same-cycle software ready clear.
// R23: Writing one to hardware flags does nothing.
`timescale 1ns/100ps
`default_nettype none
module adc_status_regs
    import adc_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire sfr_req_t sfr_i,
    input wire bit_req_t bit_i,
    input wire conv_event_t p_ev_i,
    input wire conv_event_t a_ev_i,
    input wire logic ref_low_i,
    input wire logic ext_ref_sel_i,
    output logic [7:0] sfr_rdata_o,
    output logic bit_rdata_o,
    output logic [7:0] status_o,
    output logic [2:0] mode_o,
    output logic p_en_o,
    output logic a_en_o,
    output logic [7:0] decim_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] decim;
    logic [7:0] status;
    logic [7:0] next_rdata;
    logic cal_flag;
    logic noref;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic ref_low_q;
    logic active;
    logic force_ones;
    logic start;
    logic mode_wr;
    logic p_rdy;
    logic a_rdy;
    logic p_err;
    logic a_err;
    logic p_cal_done;
    logic a_cal_done;
    logic [23:0] p_res;
    logic [23:0] p_off;
    logic [23:0] p_gain;
    logic [15:0] a_res;
    logic [15:0] a_off;
    logic [15:0] a_gain;

    // Software writing zero to a status bit, byte or bit access
    function automatic logic sw_zero(input sfr_req_t s, input bit_req_t b,
                                     input int idx);
        logic by_byte;
        logic by_bit;
        by_byte = s.wr & (s.addr == ADDR_STATUS) & ~s.wdata[idx];
        by_bit = b.wr & (b.addr == ADDR_STATUS + 8'(idx)) & ~b.val;
        return by_byte | by_bit;
    endfunction : sw_zero

    // ------------------------------------------------------------------
    // Mode and filter registers
    // ------------------------------------------------------------------
    assign mode_wr = sfr_i.wr & (sfr_i.addr == ADDR_MODE);
    // Any mode code at or above single conversion launches a cycle
    assign start = mode_wr & (sfr_i.wdata[2:0] >= MODE_SINGLE);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_reg <= MODE_RST;
        end else if (mode_wr) begin
            mode_reg <= sfr_i.wdata & MODE_WMASK;
        end else if (mode_reg[2:0] == MODE_SINGLE
                     && (p_ev_i.done | a_ev_i.done)) begin
            mode_reg[2:0] <= MODE_PDOWN; // R20
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            decim <= DECIM_RST;
        end else if (sfr_i.wr && sfr_i.addr == ADDR_DECIM) begin
            decim <= sfr_i.wdata; // R18
        end
    end

    assign mode_o = mode_reg[2:0];
    assign p_en_o = mode_reg[BIT_P_EN];
    assign a_en_o = mode_reg[BIT_A_EN];
    assign decim_o = decim;

    // ------------------------------------------------------------------
    // Reference detect
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
        end else begin
            ref_s1 <= ref_low_i;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_low_q <= 1'b0;
        end else if (ref_s2 == ref_s3) begin
            ref_low_q <= ref_s3;
        end
    end

    // Active needs an enable bit and a non-power-down mode
    assign active = (mode_reg[BIT_P_EN] | mode_reg[BIT_A_EN])
        & (mode_reg[2:0] != MODE_PDOWN); // R21

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            noref <= 1'b0;
        end else if (active) begin
            noref <= ref_low_q; // R06
        end
    end

    assign force_ones = noref & ext_ref_sel_i; // R07

    // ------------------------------------------------------------------
    // Converter channels
    // ------------------------------------------------------------------
    conv_channel #(
        .W(24),
        .OFF_INIT(FACT_P_OFF),
        .GAIN_INIT(FACT_P_GAIN)
    ) u_primary (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ev_i(p_ev_i),
        .start_i(start),
        .sw_clr_i(sw_zero(sfr_i, bit_i, BIT_P_RDY)), // R02
        .force_ones_i(force_ones),
        .ready_o(p_rdy),
        .error_o(p_err),
        .cal_done_o(p_cal_done),
        .result_o(p_res),
        .offset_o(p_off),
        .gain_o(p_gain)
    );

    conv_channel #(
        .W(16),
        .OFF_INIT(FACT_A_OFF),
        .GAIN_INIT(FACT_A_GAIN)
    ) u_aux (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ev_i(a_ev_i),
        .start_i(start),
        .sw_clr_i(sw_zero(sfr_i, bit_i, BIT_A_RDY)), // R04
        .force_ones_i(force_ones),
        .ready_o(a_rdy),
        .error_o(a_err),
        .cal_done_o(a_cal_done),
        .result_o(a_res),
        .offset_o(a_off),
        .gain_o(a_gain)
    );

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    // Only hardware sets this; software ones are ignored
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cal_flag <= 1'b0;
        end else if (p_cal_done | a_cal_done) begin
            cal_flag <= 1'b1; // R05 R23
        end else if (start) begin
            cal_flag <= 1'b0;
        end
    end

    // Reserved bits 1:0 read zero
    assign status = {p_rdy, a_rdy, cal_flag, noref,
                     p_err, a_err, 2'b00}; // R12 R11
    assign status_o = status;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        case (sfr_i.addr)
            ADDR_STATUS: next_rdata = status;
            ADDR_MODE: next_rdata = mode_reg;
            ADDR_DECIM: next_rdata = decim;
            ADDR_P_RES_L: next_rdata = p_res[7:0]; // R13
            ADDR_P_RES_M: next_rdata = p_res[15:8];
            ADDR_P_RES_H: next_rdata = p_res[23:16];
            ADDR_A_RES_L: next_rdata = a_res[7:0]; // R14
            ADDR_A_RES_H: next_rdata = a_res[15:8];
            ADDR_P_OFF_L: next_rdata = p_off[7:0]; // R15
            ADDR_P_OFF_M: next_rdata = p_off[15:8];
            ADDR_P_OFF_H: next_rdata = p_off[23:16];
            ADDR_P_GAIN_L: next_rdata = p_gain[7:0];
            ADDR_P_GAIN_M: next_rdata = p_gain[15:8];
            ADDR_P_GAIN_H: next_rdata = p_gain[23:16];
            ADDR_A_OFF_L: next_rdata = a_off[7:0]; // R16
            ADDR_A_OFF_H: next_rdata = a_off[15:8];
            ADDR_A_GAIN_L: next_rdata = a_gain[7:0];
            ADDR_A_GAIN_H: next_rdata = a_gain[15:8];
            default: next_rdata = 8'h00; // R19
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_i.rd) begin
            sfr_rdata_o <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bit_rdata_o <= 1'b0;
        end else if (bit_i.addr[7:3] == ADDR_STATUS[7:3]) begin
            bit_rdata_o <= status[bit_i.addr[2:0]]; // R12
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    logic p_acc;
    logic a_acc;
    assign p_acc = p_ev_i.done & ~p_rdy;
    assign a_acc = a_ev_i.done & ~a_rdy;

    property p_rdy_set; // R01
        p_ev_i.done |=> p_rdy;
    endproperty
    a_rdy_set: assert property (p_rdy_set) // R01
        else $error("primary ready not set after completion");

    property p_rdy_clr; // R02
        start && !p_ev_i.done && !a_acc |=> !p_rdy && !cal_flag;
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) // R02
        else $error("primary ready not cleared by start");

    property p_block; // R03
        p_rdy && p_ev_i.done && !start
            |=> $stable(p_res) && $stable(p_off) && $stable(p_gain);
    endproperty
    a_block: assert property (p_block) // R03
        else $error("blocked primary result was written");

    property p_aux_rdy; // R04
        a_rdy && a_ev_i.done |=> a_rdy && $stable(a_res);
    endproperty
    a_aux_rdy: assert property (p_aux_rdy) // R04
        else $error("auxiliary ready or result misbehaved");

    property p_cal_set; // R05
        p_acc && p_ev_i.is_cal |=> cal_flag;
    endproperty
    a_cal_set: assert property (p_cal_set) // R05
        else $error("calibration flag not set");

    property p_noref; // R06
        !active |=> $stable(noref);
    endproperty
    a_noref: assert property (p_noref) // R06
        else $error("reference flag moved while inactive");

    property p_force; // R07
        p_acc && !p_ev_i.is_cal && force_ones
            |=> p_res == 24'hffffff && p_err;
    endproperty
    a_force: assert property (p_force) // R07
        else $error("result not forced to ones");

    property p_clamp; // R08
        p_acc && p_ev_i.clamped |=> p_err [*2] or start;
    endproperty
    a_clamp: assert property (p_clamp) // R08
        else $error("clamp did not set primary error");

    property p_calfail; // R09
        p_acc && p_ev_i.is_cal && p_ev_i.cal_fail
            |=> p_err && p_off == $past(p_off);
    endproperty
    a_calfail: assert property (p_calfail) // R09
        else $error("failed calibration mishandled");

    property p_err_clr; // R10
        start && !p_acc && !a_acc |=> !p_err && !a_err;
    endproperty
    a_err_clr: assert property (p_err_clr) // R10
        else $error("error flags not cleared by start");

    property p_rst_val; // R12
        $fell(rst_i) |-> status == STATUS_RST && p_off == FACT_P_OFF;
    endproperty
    a_rst_val: assert property (p_rst_val) // R12
        else $error("status or coefficient reset value wrong");

    property p_single; // R20
        mode_reg[2:0] == MODE_SINGLE && p_ev_i.done && !mode_wr
            |=> mode_o == MODE_PDOWN;
    endproperty
    a_single: assert property (p_single) // R20
        else $error("single conversion did not return to power-down");

    property p_set_wins; // R22
        p_acc && sw_zero(sfr_i, bit_i, BIT_P_RDY) |=> p_rdy;
    endproperty
    a_set_wins: assert property (p_set_wins) // R22
        else $error("software clear beat completion");

    property p_sw_one; // R23
        !cal_flag && !p_cal_done && !a_cal_done |=> !cal_flag;
    endproperty
    a_sw_one: assert property (p_sw_one) // R23
        else $error("calibration flag set without calibration");

    property p_read_res; // R13
        sfr_i.rd && sfr_i.addr == ADDR_P_RES_H
            |=> sfr_rdata_o == $past(p_res[23:16]);
    endproperty
    a_read_res: assert property (p_read_res) // R13
        else $error("result high byte read wrong");

    c_single: cover property (mode_wr ##[1:20] mode_o == MODE_PDOWN);
    c_blocked: cover property (p_rdy && p_ev_i.done);
    c_calfail: cover property (p_acc && p_ev_i.cal_fail);
    c_force: cover property (force_ones && p_acc);

endmodule : adc_status_regs
`default_nettype wire

// >>> dv/cpu_host_model.sv
// Behavioural CPU core model driving the SFR byte and bit buses.
// Assumes the buses are sampled on the rising edge of sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module cpu_host_model
    import adc_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [7:0] sfr_rdata_i,
    output var sfr_req_t sfr_o,
    output var bit_req_t bit_o
);
    // ------------------------------------------------------------------
    // Bus tasks; released byte bus shows inverted values, bit bus inverts only the value
    // ------------------------------------------------------------------
    initial begin
        sfr_o = '0;
        bit_o = '0;
    end

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        sfr_o <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(posedge sys_clk_i);
        sfr_o <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        sfr_o <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge sys_clk_i);
        sfr_o <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: 8'hff};
        #1;
        d = sfr_rdata_i;
    endtask : sfr_read

    // Software clears a ready flag by writing zero
    task automatic bit_write(input logic [7:0] a, input logic v);
        @(posedge sys_clk_i);
        bit_o <= '{addr: a, wr: 1'b1, val: v};
        @(posedge sys_clk_i);
        bit_o <= '{addr: a, wr: 1'b0, val: ~v};
    endtask : bit_write
endmodule : cpu_host_model
`default_nettype wire

// >>> dv/tb_adc_status_regs.sv
// Self-checking testbench for the converter status and result block.
// Assumes cpu_host_model drives the SFR buses; events come from here.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_status_regs;
    import adc_regs_pkg::*;
    logic sys_clk;
    logic rst;
    sfr_req_t sfr;
    bit_req_t bitr;
    conv_event_t p_ev;
    conv_event_t a_ev;
    logic ref_low;
    logic ext_ref_sel;
    logic [7:0] sfr_rdata;
    logic bit_rdata;
    logic [7:0] status_o;
    logic [2:0] mode_o;
    logic p_en_o;
    logic a_en_o;
    logic [7:0] decim_o;
    int n_fail = 0;
    int cmp_count = 0;
    logic [7:0] ra [8];
    logic [7:0] rv [8];

    adc_status_regs u_adc_status_regs (
        .sys_clk_i(sys_clk), .rst_i(rst), .sfr_i(sfr), .bit_i(bitr),
        .p_ev_i(p_ev), .a_ev_i(a_ev), .ref_low_i(ref_low),
        .ext_ref_sel_i(ext_ref_sel), .sfr_rdata_o(sfr_rdata),
        .bit_rdata_o(bit_rdata), .status_o(status_o), .mode_o(mode_o),
        .p_en_o(p_en_o), .a_en_o(a_en_o), .decim_o(decim_o)
    );
    cpu_host_model u_cpu_host_model (
        .sys_clk_i(sys_clk), .sfr_rdata_i(sfr_rdata), .sfr_o(sfr),
        .bit_o(bitr)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_cpu_host_model.sfr_read(a, d);
        chk(d, exp);
    endtask : rdchk

    task automatic fire(input logic prim, input logic cal, input logic clp,
                        input logic fail, input logic [23:0] r,
                        input logic [23:0] o, input logic [23:0] g);
        conv_event_t e;
        e = '{done: 1'b1, is_cal: cal, clamped: clp, cal_fail: fail,
              result: r, offset: o, gain: g};
        @(posedge sys_clk);
        if (prim) p_ev <= e;
        else a_ev <= e;
        e = ~e;
        e.done = 1'b0;
        @(posedge sys_clk);
        if (prim) p_ev <= e;
        else a_ev <= e;
        @(posedge sys_clk);
        #1;
    endtask : fire

    task automatic wait_ref(input logic v);
        int i;
        for (i = 0; i < 20 && status_o[BIT_NOREF] !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (status_o[BIT_NOREF] !== v) begin
            n_fail++;
            $display("wrong value at %0t: reference flag timeout", $time);
            report_and_stop();
        end
    endtask : wait_ref

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        p_ev = '0;
        a_ev = '0;
        ref_low = 1'b0;
        ext_ref_sel = 1'b0;
        ra = '{ADDR_P_OFF_L, ADDR_P_OFF_H, ADDR_P_GAIN_H, ADDR_A_OFF_H,
               ADDR_A_GAIN_H, ADDR_DECIM, ADDR_P_RES_L, 8'h80};
        rv = '{FACT_P_OFF[7:0], FACT_P_OFF[23:16], FACT_P_GAIN[23:16],
               FACT_A_OFF[15:8], FACT_A_GAIN[15:8], DECIM_RST, 8'h00, 8'h00};
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(status_o, STATUS_RST);
        chk({p_en_o, a_en_o, 3'h0, mode_o}, MODE_RST);
        for (int k = 0; k < 8; k++)
            rdchk(ra[k], rv[k]);
        $display("test reset done");

        fire(1'b1, 1'b0, 1'b0, 1'b0, 24'h123456, 24'h0, 24'h0);
        chk(status_o, 8'h80);
        rdchk(ADDR_P_RES_L, 8'h56);
        rdchk(ADDR_P_RES_M, 8'h34);
        rdchk(ADDR_P_RES_H, 8'h12);
        fire(1'b1, 1'b0, 1'b1, 1'b0, 24'h654321, 24'h0, 24'h0);
        rdchk(ADDR_P_RES_L, 8'h56);
        chk(status_o, 8'h80);
        u_cpu_host_model.bit_write(8'hdf, 1'b0);
        #1;
        chk(status_o, 8'h00);
        $display("test primary ready done");

        fire(1'b0, 1'b0, 1'b1, 1'b0, 24'h00abcd, 24'h0, 24'h0);
        chk(status_o, 8'h44);
        rdchk(ADDR_A_RES_L, 8'hcd);
        rdchk(ADDR_A_RES_H, 8'hab);
        u_cpu_host_model.sfr_write(ADDR_STATUS, 8'h3c);
        #1;
        chk(status_o, 8'h04);
        $display("test aux ready done");

        u_cpu_host_model.sfr_write(ADDR_MODE, 8'h22);
        #1;
        chk(status_o, 8'h00);
        chk({p_en_o, a_en_o, 3'h0, mode_o}, 8'h82);
        fire(1'b1, 1'b1, 1'b0, 1'b0, 24'h0, 24'h112233, 24'h445566);
        chk(status_o, 8'ha0);
        chk({5'h0, mode_o}, 8'h00);
        rdchk(ADDR_P_OFF_L, 8'h33);
        rdchk(ADDR_P_GAIN_H, 8'h44);
        fire(1'b0, 1'b1, 1'b0, 1'b1, 24'h0, 24'h001234, 24'h005678);
        chk(status_o, 8'he4);
        rdchk(ADDR_A_OFF_H, FACT_A_OFF[15:8]);
        rdchk(ADDR_A_GAIN_L, FACT_A_GAIN[7:0]);
        $display("test calibration done");

        u_cpu_host_model.sfr_write(ADDR_STATUS, 8'h00);
        #1;
        chk(status_o, 8'h24);
        fork
            u_cpu_host_model.bit_write(8'hdf, 1'b0);
            fire(1'b1, 1'b0, 1'b0, 1'b0, 24'h000777, 24'h0, 24'h0);
        join
        chk(status_o, 8'ha4);
        chk({7'h0, bit_rdata}, 8'h01);
        u_cpu_host_model.sfr_write(ADDR_DECIM, 8'h12);
        #1;
        chk(decim_o, 8'h12);
        rdchk(ADDR_DECIM, 8'h12);
        $display("test collision and filter done");

        u_cpu_host_model.bit_write(8'hdf, 1'b0);
        u_cpu_host_model.sfr_write(ADDR_MODE, 8'h31);
        #1;
        chk({p_en_o, a_en_o, 3'h0, mode_o}, 8'hc1);
        chk({7'h0, bit_rdata}, 8'h00);
        @(posedge sys_clk);
        ref_low <= 1'b1;
        ext_ref_sel <= 1'b1;
        wait_ref(1'b1);
        chk(status_o, 8'h34);
        fire(1'b1, 1'b0, 1'b0, 1'b0, 24'h000001, 24'h0, 24'h0);
        rdchk(ADDR_P_RES_L, 8'hff);
        rdchk(ADDR_P_RES_H, 8'hff);
        chk(status_o, 8'hbc);
        @(posedge sys_clk);
        ref_low <= 1'b0;
        wait_ref(1'b0);
        chk(status_o, 8'hac);
        $display("test reference done");
        report_and_stop();
    end
endmodule : tb_adc_status_regs
`default_nettype wire
